// *** rtl/sleep_wake_defines.svh ***
// Constants for the sleep, wake and host-detect controller
`ifndef SLEEP_WAKE_DEFINES_SVH
`define SLEEP_WAKE_DEFINES_SVH

`define CLK_FREQ_HZ        125000000
`define SLOW_CLK_HZ        32768
// Core clocks per slow-clock tick, used to pace the sleep timer in light and deep sleep
`define SLOW_TICK_CYCLES   (`CLK_FREQ_HZ / `SLOW_CLK_HZ)
`define SLOW_TICK_W        12
`define TIMEOUT_W          32
`define CAUSE_W            6
`define CAUSE_TIMER        0
`define CAUSE_PIN          1
`define CAUSE_COMPARATOR   2
`define CAUSE_RTC          3
`define CAUSE_WATCHDOG     4
`define CAUSE_HOST         5
`define PORT_RESET         3'h0

`endif

// *** rtl/sleep_wake_pkg.sv ***
// Types for the sleep, wake and host-detect controller
package sleep_wake_pkg;

    typedef enum logic [2:0] {
        port_none_type_val  = 3'h0,
        port_sdio           = 3'h1,
        port_spi            = 3'h2,
        port_uart           = 3'h3,
        port_usb_native     = 3'h4,
        port_usb_cdc        = 3'h5
    } host_port_type;

    typedef enum logic [1:0] {
        mode_normal      = 2'h0,
        light_sleep_mode = 2'h1,
        deep_sleep_mode  = 2'h2
    } power_mode_type;

    typedef struct packed {
        logic sdio_seen;
        logic spi_seen;
        logic uart_seen;
        logic vbus;
        logic cdc_select_pin;
    } detect_in_type;

    typedef struct packed {
        logic timer;
        logic pin;
        logic comparator;
        logic rtc;
        logic watchdog;
        logic host;
    } wake_cause_type;

endpackage

// *** rtl/sleep_wake_host_detect.sv ***
// Power-mode controller with host-interface detection and wake handling
//
// Summary of operation
// - Hardware flags SDIO or SPI host from packets
// - USB device mode chosen when VBUS present
// - Software reports UART host from received packets
// - CDC select pin picks native or CDC USB
// - Port choice stored once, reused on wake
// - Deep sleep paced by 32 kHz tick
// - Deep sleep gates all subsystems, timer runs
// - Programmed timeout ends deep sleep
// - Wake pin at chosen polarity ends sleep
// - Comparator event ends deep sleep
// - RTC timeout ends deep sleep
// - Watchdog interrupt ends deep sleep
// - No deep sleep while port is USB
// - Light sleep gates clocks, host port ready
// - Host command wakes, regates after done
// - Wake pin also ends light sleep
// - Programmed timeout also ends light sleep
// - Unused clocks gated, self-entry to sleep
`timescale 1ns/1ps
`include "sleep_wake_defines.svh"
`default_nettype none

module sleep_wake_host_detect (
    input  wire logic                          core_clk,          // 125 MHz clock
    input  wire logic                          reset_n,           // Power-on reset, active low
    input  wire logic                          sdio_packet_seen,  // SDIO packet exchange pulse
    input  wire logic                          spi_packet_seen,   // SPI packet exchange pulse
    input  wire logic                          uart_host_found,   // Firmware UART verdict pulse
    input  wire logic                          usb_vbus,          // VBUS level pin
    input  wire logic                          cdc_select_pin,    // CDC select pin
    input  wire logic                          sleep_request,     // Pulse: enter requested mode
    input  wire logic                          sleep_deep,        // 1 deep, 0 light sleep
    input  wire logic                          idle_request,      // Auto-entry hint, level
    input  wire logic [`TIMEOUT_W-1:0]          timeout_count,     // Wake timeout, slow ticks
    input  wire logic                          timeout_enable,    // Timeout wake enable
    input  wire logic                          wake_pin,          // Wake pin
    input  wire logic                          wake_pin_polarity, // 1 wake on high
    input  wire logic                          wake_pin_enable,   // Pin wake enable
    input  wire logic                          comparator_event,  // Comparator event pin
    input  wire logic                          rtc_timeout,       // RTC timeout pin
    input  wire logic                          watchdog_irq,      // Watchdog interrupt pin
    input  wire logic                          host_command,      // Host command arrival pulse
    input  wire logic                          host_op_done,      // Host operation done pulse
    input  wire logic                          ram_retain,        // Keep RAM in deep sleep
    input  wire logic                          cause_clear,       // Pulse: clear wake causes
    input  wire logic [`CAUSE_W-1:0]            block_in_use,      // Per-block activity
    output var  sleep_wake_pkg::host_port_type host_port,         // Stored host port
    output logic                               port_valid,        // Port has been detected
    output var  sleep_wake_pkg::power_mode_type power_mode,       // Current power mode
    output logic                               hf_clock_enable,   // High-frequency clock gate
    output logic [`CAUSE_W-1:0]                block_clock_enable,// Per-block clock gates
    output logic                               subsystem_active,  // Subsystems powered up
    output logic                               ram_retained,      // RAM held in deep sleep
    output logic                               host_port_ready,   // Host port accepts commands
    output logic                               wake_event,        // One-cycle wake pulse
    output logic [`CAUSE_W-1:0]                wake_cause,        // Sticky wake causes
    output logic                               sleep_refused      // Deep sleep refused pulse
);

    // ==========================================================
    // Input synchronisers
    logic [1:0] vbus_sync;
    logic [1:0] cdc_sync;
    logic [1:0] pin_sync;
    logic [1:0] cmp_sync;
    logic [1:0] rtc_sync;
    logic [1:0] wdg_sync;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            vbus_sync <= 2'h0;
            cdc_sync  <= 2'h0;
            pin_sync  <= 2'h0;
            cmp_sync  <= 2'h0;
            rtc_sync  <= 2'h0;
            wdg_sync  <= 2'h0;
        end else begin
            vbus_sync <= {vbus_sync[0], usb_vbus};
            cdc_sync  <= {cdc_sync[0], cdc_select_pin};
            pin_sync  <= {pin_sync[0], wake_pin};
            cmp_sync  <= {cmp_sync[0], comparator_event};
            rtc_sync  <= {rtc_sync[0], rtc_timeout};
            wdg_sync  <= {wdg_sync[0], watchdog_irq};
        end
    end

    logic vbus_s;
    logic cdc_s;
    logic pin_s;
    assign vbus_s = vbus_sync[1];
    assign cdc_s  = cdc_sync[1];
    assign pin_s  = pin_sync[1];

    // ==========================================================
    // Host-port detection, always-on
    logic next_detect_valid;
    sleep_wake_pkg::host_port_type next_port;

    always_comb begin
        next_detect_valid = 1'b0;
        next_port         = sleep_wake_pkg::port_none_type_val;
        if (vbus_s) begin
            next_detect_valid = 1'b1;
            next_port = cdc_s ? sleep_wake_pkg::port_usb_cdc
                              : sleep_wake_pkg::port_usb_native;
        end else if (sdio_packet_seen) begin
            next_detect_valid = 1'b1;
            next_port = sleep_wake_pkg::port_sdio;
        end else if (spi_packet_seen) begin
            next_detect_valid = 1'b1;
            next_port = sleep_wake_pkg::port_spi;
        end else if (uart_host_found) begin
            next_detect_valid = 1'b1;
            next_port = sleep_wake_pkg::port_uart;
        end
    end

    // Only reset_n clears this; wakeup never touches it
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            host_port  <= sleep_wake_pkg::port_none_type_val;
            port_valid <= 1'b0;
        end else if (!port_valid && next_detect_valid) begin
            host_port  <= next_port;
            port_valid <= 1'b1;
        end
    end

    // Both USB flavours share the deep-sleep ban
    function automatic logic is_usb_port(input sleep_wake_pkg::host_port_type port);
        return port == sleep_wake_pkg::port_usb_native ||
               port == sleep_wake_pkg::port_usb_cdc;
    endfunction

    logic port_is_usb;
    assign port_is_usb = port_valid && is_usb_port(host_port);

    // ==========================================================
    // Slow tick and timeout counter
    logic [`SLOW_TICK_W-1:0] tick_div;
    logic                    slow_tick;
    logic [`TIMEOUT_W-1:0]   sleep_timer;
    logic                    timer_expired;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_div  <= '0;
            slow_tick <= 1'b0;
        end else if (tick_div == `SLOW_TICK_W'(`SLOW_TICK_CYCLES - 1)) begin
            tick_div  <= '0;
            slow_tick <= 1'b1;
        end else begin
            tick_div  <= tick_div + `SLOW_TICK_W'(1);
            slow_tick <= 1'b0;
        end
    end

    logic asleep;
    assign asleep = power_mode != sleep_wake_pkg::mode_normal;

    // Counter only runs while asleep, so a short timeout set awake is harmless
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sleep_timer <= '0;
        end else if (!asleep) begin
            sleep_timer <= '0;
        end else if (slow_tick && !timer_expired) begin
            sleep_timer <= sleep_timer + `TIMEOUT_W'(1);
        end
    end

    assign timer_expired = timeout_enable && asleep &&
                           (sleep_timer >= timeout_count);

    // ==========================================================
    // Wake source merge
    logic [`CAUSE_W-1:0] src;
    logic                pin_active;
    logic                deep;

    assign deep       = power_mode == sleep_wake_pkg::deep_sleep_mode;
    assign pin_active = wake_pin_enable && (pin_s == wake_pin_polarity);

    always_comb begin
        src = '0;
        src[`CAUSE_TIMER]      = timer_expired;
        src[`CAUSE_PIN]        = pin_active;
        src[`CAUSE_COMPARATOR] = deep && cmp_sync[1];
        src[`CAUSE_RTC]        = deep && rtc_sync[1];
        src[`CAUSE_WATCHDOG]   = deep && wdg_sync[1];
        src[`CAUSE_HOST]       = (power_mode == sleep_wake_pkg::light_sleep_mode)
                                 && host_command;
    end

    logic wake_now;
    assign wake_now = asleep && (src != '0);

    // Causes set while sleeping; a set beats a clear in the same cycle
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_cause <= '0;
        end else if (wake_now) begin
            wake_cause <= (cause_clear ? '0 : wake_cause) | src;
        end else if (cause_clear) begin
            wake_cause <= '0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_event <= 1'b0;
        end else begin
            wake_event <= wake_now;
        end
    end

    // ==========================================================
    // Power-mode sequencing
    logic serving_host;
    logic enter_req;
    assign enter_req = sleep_request || idle_request;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            power_mode    <= sleep_wake_pkg::mode_normal;
            sleep_refused <= 1'b0;
            serving_host  <= 1'b0;
        end else begin
            sleep_refused <= 1'b0;
            case (power_mode)
                sleep_wake_pkg::mode_normal: begin
                    if (serving_host && host_op_done) begin
                        serving_host <= 1'b0;
                        power_mode   <= sleep_wake_pkg::light_sleep_mode;
                    end else if (!serving_host && enter_req) begin
                        if (sleep_deep && port_is_usb) begin
                            sleep_refused <= 1'b1;
                        end else if (sleep_deep) begin
                            power_mode <= sleep_wake_pkg::deep_sleep_mode;
                        end else begin
                            power_mode <= sleep_wake_pkg::light_sleep_mode;
                        end
                    end
                end
                sleep_wake_pkg::light_sleep_mode: begin
                    if (wake_now) begin
                        power_mode   <= sleep_wake_pkg::mode_normal;
                        serving_host <= src == `CAUSE_W'(1 << `CAUSE_HOST);
                    end
                end
                sleep_wake_pkg::deep_sleep_mode: begin
                    if (wake_now) begin
                        power_mode <= sleep_wake_pkg::mode_normal;
                    end
                end
                default: begin
                    power_mode <= sleep_wake_pkg::mode_normal;
                end
            endcase
        end
    end

    // ==========================================================
    // Clock and power gating
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hf_clock_enable    <= 1'b1;
            block_clock_enable <= '0;
            subsystem_active   <= 1'b1;
            ram_retained       <= 1'b1;
            host_port_ready    <= 1'b1;
        end else begin
            hf_clock_enable    <= !asleep || wake_now;
            block_clock_enable <= asleep ? '0 : block_in_use;
            subsystem_active   <= !deep || wake_now;
            ram_retained       <= !deep || ram_retain;
            host_port_ready    <= !deep;
        end
    end

endmodule

`default_nettype wire

// *** bench/sleep_wake_host_detect_chk.sv ***
// Port assertions for the sleep, wake and host-detect controller
`timescale 1ns/1ps
`include "sleep_wake_defines.svh"
`default_nettype none
module sleep_wake_host_detect_chk (
    input wire logic core_clk, reset_n, usb_vbus, cdc_select_pin, // Clock, reset, pins
    input wire logic sleep_request, sleep_deep, host_command, cause_clear, // Requests
    input wire logic comparator_event, rtc_timeout, watchdog_irq, // Deep wake pins
    input wire logic port_valid, hf_clock_enable, subsystem_active, // Status
    input wire logic host_port_ready, wake_event, sleep_refused, // Status
    input var sleep_wake_pkg::host_port_type host_port, // Stored port
    input var sleep_wake_pkg::power_mode_type power_mode, // Mode
    input wire logic [`CAUSE_W-1:0] wake_cause // Causes
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    // ============================================================
    // Port detection
    AST_PORT_HELD: assert property (port_valid |=> port_valid && $stable(host_port))
        else $error("stored port moved");
    AST_USB_CDC: assert property ((!port_valid && usb_vbus && cdc_select_pin) [*3] |->
        ##[0:2] host_port == sleep_wake_pkg::port_usb_cdc) else $error("usb cdc not taken");
    AST_REFUSE: assert property (power_mode == sleep_wake_pkg::mode_normal &&
        sleep_request && sleep_deep && host_port[2] |=> sleep_refused &&
        power_mode == sleep_wake_pkg::mode_normal) else $error("usb deep not refused");
    // ============================================================
    // Sleep and wake
    AST_LIGHT_GATE: assert property (power_mode == sleep_wake_pkg::light_sleep_mode [*2]
        |-> !hf_clock_enable && host_port_ready) else $error("light sleep gating wrong");
    AST_HOST_WAKE: assert property (power_mode == sleep_wake_pkg::light_sleep_mode &&
        host_command |=> wake_event && wake_cause[5] &&
        power_mode == sleep_wake_pkg::mode_normal) else $error("host command no wake");
    AST_DEEP_GATE: assert property (power_mode == sleep_wake_pkg::deep_sleep_mode [*3]
        |-> !subsystem_active && !host_port_ready) else $error("deep sleep not gated");
    AST_DEEP_SRC: assert property ((power_mode == sleep_wake_pkg::deep_sleep_mode &&
        (comparator_event || rtc_timeout || watchdog_irq)) [*3] |-> ##[0:2] wake_event)
        else $error("deep source no wake");
    AST_CAUSE_KEPT: assert property (!cause_clear |=>
        (wake_cause & $past(wake_cause)) == $past(wake_cause)) else $error("cause lost");
endmodule
`default_nettype wire

// *** bench/host_model.sv ***
// Host processor model: attaches on one port and sends commands
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic                            core_clk,     // Clock
    input  wire logic                            reset_n,      // Reset, active low
    input  wire logic [2:0]                      attach,       // Port code used, 0 none
    input  wire logic                            cmd_go,       // Pulse: send a command
    input  wire logic [3:0]                      serve_wait,   // Cycles to serve it
    input  wire logic                            deep_now,     // Device in deep sleep
    output var  sleep_wake_pkg::detect_in_type   det,          // Detect lines
    output logic                                 host_command, // Command pulse
    output logic                                 host_op_done, // Served pulse
    output logic                                 irq_enable    // Interrupt input on
);
    logic [3:0] pace;
    logic [3:0] busy;
    // ============================================================
    // Exchanges repeat, so late ones probe that the stored port holds
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pace <= 4'h0;
            det <= '0;
        end else begin
            pace <= pace + 4'h1;
            det <= '{attach == 3'h1 && pace == 4'h0, attach == 3'h2 && pace == 4'h0,
                     attach == 3'h3 && pace == 4'h0, attach[2], attach == 3'h5};
        end
    end
    // ============================================================
    // Commands
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 4'h0;
            host_command <= 1'b0;
            host_op_done <= 1'b0;
            irq_enable <= 1'b0;
        end else begin
            host_command <= cmd_go;
            host_op_done <= busy == 4'h1;
            busy <= cmd_go ? serve_wait : busy - {3'h0, busy != 4'h0};
            // Off across deep sleep, on again once a command set the port up
            if (deep_now)
                irq_enable <= 1'b0;
            else if (host_command)
                irq_enable <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** bench/sleep_wake_host_detect_tb.sv ***
// Self-checking bench for the sleep, wake and host-detect controller
`timescale 1ns/1ps
`include "sleep_wake_defines.svh"
`default_nettype none
module sleep_wake_host_detect_tb;
    logic core_clk = 1'b0;
    logic reset_n;
    logic sleep_request = 1'b0, sleep_deep = 1'b0, idle_request = 1'b0, cause_clear = 1'b0;
    logic wake_pin = 1'b1, wake_pin_polarity = 1'b0, wake_pin_enable = 1'b0, cmd_go = 1'b0;
    logic timeout_enable = 1'b0, ram_retain = 1'b1, irq_enable, host_command, host_op_done;
    logic comparator_event = 1'b0, rtc_timeout = 1'b0, watchdog_irq = 1'b0;
    logic [2:0] attach = 3'h0;
    logic [3:0] serve_wait = 4'h2;
    logic [`TIMEOUT_W-1:0] timeout_count = 32'h0;
    logic [`CAUSE_W-1:0] block_in_use = 6'h0, block_clock_enable, wake_cause;
    logic port_valid, hf_clock_enable, subsystem_active, ram_retained, host_port_ready;
    logic wake_event, sleep_refused;
    sleep_wake_pkg::detect_in_type det;
    sleep_wake_pkg::host_port_type host_port;
    sleep_wake_pkg::power_mode_type power_mode;
    wire logic deep_now = power_mode == sleep_wake_pkg::deep_sleep_mode;
    wire logic sdio_packet_seen = det.sdio_seen;
    wire logic spi_packet_seen = det.spi_seen;
    wire logic uart_host_found = det.uart_seen;
    wire logic usb_vbus = det.vbus;
    wire logic cdc_select_pin = det.cdc_select_pin;
    int fails = 0, n_tests = 0, cycles = 0;
    host_model host (.*);
    sleep_wake_host_detect DUT (.*);
    initial forever #4 core_clk = ~core_clk;
    // ============================================================
    // Run control
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fails = fails + 1;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // ============================================================
    // Access tasks
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic do_reset(input logic [2:0] port);
        @(posedge core_clk);
        reset_n <= 1'b0;
        attach <= port;
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        settle(20);
    endtask
    task automatic ask(input logic deep);
        @(posedge core_clk);
        sleep_request <= 1'b1;
        sleep_deep <= deep;
        cause_clear <= 1'b1;
        @(posedge core_clk);
        sleep_request <= 1'b0;
        cause_clear <= 1'b0;
        #1;
    endtask
    task automatic wake_by(input int lim, input logic [7:0] cause);
        for (int k = 0; k < lim && wake_event !== 1'b1; k++)
            settle(1);
        chk("wake", 8'h01, wake_event);
        chk("cause", cause, wake_cause);
        chk("mode", 8'h00, power_mode);
    endtask
    // ============================================================
    // Tests
    initial begin
        reset_n <= 1'b0;
        do_reset(3'h2);
        chk("port", 8'h02, host_port);
        @(posedge core_clk);
        attach <= 3'h1;
        block_in_use <= 6'h15;
        settle(20);
        chk("port", 8'h02, host_port);
        chk("blocks", 8'h15, block_clock_enable);
        @(posedge core_clk) idle_request <= 1'b1;
        settle(3);
        chk("mode", 8'h01, power_mode);
        chk("hf", 8'h00, hf_clock_enable);
        chk("ready", 8'h01, host_port_ready);
        @(posedge core_clk);
        idle_request <= 1'b0;
        cmd_go <= 1'b1;
        serve_wait <= 4'h9;
        @(posedge core_clk) cmd_go <= 1'b0;
        wake_by(10, 8'h20);
        settle(3);
        chk("mode", 8'h00, power_mode);
        settle(10);
        chk("mode", 8'h01, power_mode);
        @(posedge core_clk);
        wake_pin_enable <= 1'b1;
        wake_pin <= 1'b0;
        wake_by(10, 8'h22);
        @(posedge core_clk);
        wake_pin <= 1'b1;
        wake_pin_enable <= 1'b0;
        ask(1'b0);
        @(posedge core_clk) timeout_enable <= 1'b1;
        wake_by(4000, 8'h01);
        @(posedge core_clk) timeout_enable <= 1'b0;
        $display("test light sleep done");
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk) ram_retain <= i[0];
            ask(1'b1);
            settle(2);
            chk("sub", 8'h00, subsystem_active);
            chk("ram", {7'h0, ram_retain}, ram_retained);
            @(posedge core_clk) {watchdog_irq, rtc_timeout, comparator_event} <= 3'h1 << i;
            wake_by(10, 8'h04 << i);
            @(posedge core_clk) {watchdog_irq, rtc_timeout, comparator_event} <= 3'h0;
        end
        @(posedge core_clk);
        wake_pin_polarity <= 1'b1;
        wake_pin <= 1'b0;
        ask(1'b1);
        @(posedge core_clk);
        wake_pin_enable <= 1'b1;
        cmd_go <= 1'b1;
        @(posedge core_clk) cmd_go <= 1'b0;
        settle(8);
        chk("mode", 8'h02, power_mode);
        @(posedge core_clk) wake_pin <= 1'b1;
        wake_by(10, 8'h02);
        chk("irq", 8'h00, irq_enable);
        @(posedge core_clk) wake_pin_enable <= 1'b0;
        ask(1'b1);
        @(posedge core_clk) {watchdog_irq, rtc_timeout, comparator_event} <= 3'h5;
        wake_by(10, 8'h14);
        settle(1);
        chk("wake", 8'h00, wake_event);
        @(posedge core_clk);
        {watchdog_irq, rtc_timeout, comparator_event} <= 3'h0;
        timeout_count <= 32'h2;
        timeout_enable <= 1'b1;
        ask(1'b1);
        settle(3700);
        chk("mode", 8'h02, power_mode);
        wake_by(4500, 8'h01);
        chk("port", 8'h02, host_port);
        @(posedge core_clk) timeout_enable <= 1'b0;
        $display("test deep sleep done");
        do_reset(3'h0);
        chk("port", 8'h00, host_port);
        chk("valid", 8'h00, port_valid);
        do_reset(3'h3);
        chk("port", 8'h03, host_port);
        do_reset(3'h5);
        chk("port", 8'h05, host_port);
        ask(1'b1);
        chk("refused", 8'h01, sleep_refused);
        chk("mode", 8'h00, power_mode);
        do_reset(3'h4);
        chk("port", 8'h04, host_port);
        $display("test host detect done");
        print_verdict();
    end
endmodule
bind sleep_wake_host_detect sleep_wake_host_detect_chk u_chk (.*);
`default_nettype wire
